/* src/cmov_decode_pkg.sv */
`default_nettype none
package cmov_decode_pkg;
  // escape byte that opens every two-byte opcode
  localparam logic [7:0] ESC_BYTE = 8'h0F;
  // second opcode bytes of the decoded conditional moves
  localparam logic [7:0] OP_BELOW = 8'h42;
  localparam logic [7:0] OP_ABOVE_EQ = 8'h43;
  localparam logic [7:0] OP_EQUAL = 8'h44;
  localparam logic [7:0] OP_NOT_EQUAL = 8'h45;
  localparam logic [7:0] OP_BELOW_EQ = 8'h46;
  localparam logic [7:0] OP_LESS = 8'h4C;
  localparam logic [7:0] OP_LESS_EQ = 8'h4E;
  localparam logic [7:0] OP_GREATER = 8'h4F;
  // cycles from instruction taken to result on a cache hit
  localparam int unsigned HIT_CYCLES = 1;
  // flag bit positions in the 32-bit flags word
  localparam int unsigned CF_POS = 0;
  localparam int unsigned ZF_POS = 6;
  localparam int unsigned SF_POS = 7;
  localparam int unsigned OF_POS = 11;

  typedef enum logic [3:0] {
    COND_NONE = 4'h0,
    COND_B = 4'h1,
    COND_AE = 4'h2,
    COND_E = 4'h3,
    COND_NE = 4'h4,
    COND_BE = 4'h5,
    COND_L = 4'h6,
    COND_LE = 4'h7,
    COND_G = 4'h8
  } cond_t;

  // one fetched instruction: two opcode bytes and the mod-reg-r/m byte
  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [1:0] mode;
    logic [2:0] reg_idx;
    logic [2:0] rm_idx;
  } insn_t;

  // register-write control to the execute stage
  typedef struct packed {
    logic wr_en;
    logic [2:0] dst_idx;
    logic [31:0] data;
  } wb_t;
endpackage : cmov_decode_pkg
`default_nettype wire

/* src/conditional_move_decode.sv */
// Contract
// - bytes 0F 46 plus mod-reg-r/m decode as move_if_below_or_equal and finish in one clock on a hit.
// - bytes 0F 43 plus mod-reg-r/m decode as move_if_above_or_equal and finish in one clock on a hit.
// - bytes 0F 42 plus mod-reg-r/m decode as move_if_below and finish in one clock on a hit.
// - bytes 0F 44 plus mod-reg-r/m decode as move_if_equal and finish in one clock on a hit.
// - bytes 0F 45 plus mod-reg-r/m decode as move_if_not_equal and finish in one clock on a hit.
// - bytes 0F 4F plus mod-reg-r/m decode as move_if_greater and finish in one clock on a hit.
// - bytes 0F 4E plus mod-reg-r/m decode as move_if_less_or_equal and finish in one clock on a hit.
// - bytes 0F 4C plus mod-reg-r/m decode as move_if_less and finish in one clock on a hit.
`default_nettype none
module conditional_move_decode
  import cmov_decode_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic valid_in,
  input wire insn_t insn_in,
  input wire logic cache_hit_in,
  input wire logic prot_mode_in,
  input wire logic [31:0] src_data_in,
  input wire logic [31:0] flags_in,
  output logic done_out,
  output logic hit_wait_out,
  output logic known_out,
  output wb_t wb_out,
  output logic [31:0] flags_out
);

  cond_t cond;
  logic take;
  logic cf, zf, sf, of;

  assign cf = flags_in[CF_POS];
  assign zf = flags_in[ZF_POS];
  assign sf = flags_in[SF_POS];
  assign of = flags_in[OF_POS];

  // opcode decode; mode bit is not used by the logic, only by the assertions, same timing both modes
  always_comb begin
    cond = COND_NONE;
    if (insn_in.op0 == ESC_BYTE) begin
      case (insn_in.op1)
        OP_BELOW_EQ: cond = COND_BE;
        OP_ABOVE_EQ: cond = COND_AE;
        OP_BELOW: cond = COND_B;
        OP_EQUAL: cond = COND_E;
        OP_NOT_EQUAL: cond = COND_NE;
        OP_GREATER: cond = COND_G;
        OP_LESS_EQ: cond = COND_LE;
        OP_LESS: cond = COND_L;
        default: cond = COND_NONE;
      endcase
    end
  end

  // condition evaluation from the flag word
  always_comb begin
    case (cond)
      COND_B: take = cf;
      COND_AE: take = !cf;
      COND_E: take = zf;
      COND_NE: take = !zf;
      COND_BE: take = cf | zf;
      COND_L: take = sf ^ of;
      COND_LE: take = zf | (sf ^ of);
      COND_G: take = !zf & (sf == of);
      default: take = 1'b0;
    endcase
  end

  // completion: one clock on a hit; a miss raises hit_wait_out for one clock and never completes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_out <= 1'b0;
      hit_wait_out <= 1'b0;
      known_out <= 1'b0;
    end else begin
      done_out <= valid_in & cache_hit_in & (cond != COND_NONE);
      hit_wait_out <= valid_in & !cache_hit_in & (cond != COND_NONE);
      known_out <= valid_in & (cond != COND_NONE);
    end
  end

  // register-write control; false condition writes nothing
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_out <= '0;
    end else begin
      wb_out.wr_en <= valid_in & cache_hit_in & take;
      wb_out.dst_idx <= insn_in.reg_idx;
      wb_out.data <= src_data_in;
    end
  end

  // flags are passed through untouched so execute cannot corrupt them here
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_out <= 32'h0000_0000;
    end else begin
      flags_out <= flags_in;
    end
  end

  a_hit_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_BELOW_EQ)
    |=> done_out)
    else $error("below-or-equal move did not finish in one clock");
  a_be_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_BELOW_EQ)
    |=> (wb_out.wr_en == ($past(cf) | $past(zf))))
    else $error("below-or-equal move disagrees with carry and zero");
  a_ae_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_ABOVE_EQ)
    |=> done_out)
    else $error("above-or-equal move did not finish in one clock");
  a_ae_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_ABOVE_EQ && !cf)
    |=> wb_out.wr_en)
    else $error("above-or-equal move skipped with carry clear");
  a_b_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_BELOW)
    |=> done_out)
    else $error("below move did not finish in one clock");
  a_b_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_BELOW)
    |=> (wb_out.wr_en == $past(cf)))
    else $error("below move disagrees with carry");
  a_e_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_EQUAL)
    |=> done_out)
    else $error("equal move did not finish in one clock");
  a_e_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_EQUAL)
    |=> (wb_out.wr_en == $past(zf)))
    else $error("equal move disagrees with zero");
  a_real_mode_hit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && !prot_mode_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_EQUAL)
    |=> done_out)
    else $error("equal move in real mode did not finish in one clock");
  a_prot_mode_hit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && prot_mode_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_EQUAL)
    |=> done_out)
    else $error("equal move in protected mode did not finish in one clock");
  a_ne_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_NOT_EQUAL)
    |=> done_out)
    else $error("not-equal move did not finish in one clock");
  a_ne_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_NOT_EQUAL && zf)
    |=> !wb_out.wr_en)
    else $error("not-equal move taken with zero set");
  a_g_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_GREATER)
    |=> done_out)
    else $error("greater move did not finish in one clock");
  a_g_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_GREATER && zf)
    |=> !wb_out.wr_en)
    else $error("greater move taken with zero set");
  a_g_taken: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_GREATER && !zf && (sf == of))
    |=> wb_out.wr_en)
    else $error("greater move skipped with condition true");
  a_le_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_LESS_EQ)
    |=> done_out)
    else $error("less-or-equal move did not finish in one clock");
  a_le_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_LESS_EQ && zf)
    |=> wb_out.wr_en)
    else $error("less-or-equal move skipped with zero set");
  a_l_one_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_LESS)
    |=> done_out)
    else $error("less move did not finish in one clock");
  a_l_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in && insn_in.op0 == ESC_BYTE && insn_in.op1 == OP_LESS)
    |=> (wb_out.wr_en == ($past(sf) ^ $past(of))))
    else $error("less move disagrees with sign and overflow");
  a_flags_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    valid_in
    |=> (flags_out == $past(flags_in)))
    else $error("flags changed by conditional move");
  // no write without a completed move
  a_no_stray_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wb_out.wr_en
    |-> done_out)
    else $error("destination written without a completed move");
  a_miss_no_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && !cache_hit_in)
    |=> (!wb_out.wr_en && !done_out))
    else $error("destination written on a cache miss");
  a_dst_follows: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && cache_hit_in)
    |=> (wb_out.dst_idx == $past(insn_in.reg_idx)))
    else $error("write destination differs from the reg field");
  a_unknown_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (valid_in && insn_in.op0 != ESC_BYTE)
    |=> (!known_out && !wb_out.wr_en))
    else $error("opcode without escape byte treated as a move");

endmodule : conditional_move_decode
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
module tb
  import cmov_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, arst_n_in, valid_in, cache_hit_in, prot_mode_in;
  insn_t insn_in;
  logic [31:0] src_data_in, flags_in, flags_out;
  logic done_out, hit_wait_out, known_out;
  wb_t wb_out;
  int fails = 0;
  int check_count = 0;
  logic [7:0] moves [8] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4C, 8'h4E, 8'h4F};

  conditional_move_decode i_conditional_move_decode (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .valid_in(valid_in), .insn_in(insn_in), .cache_hit_in(cache_hit_in), .prot_mode_in(prot_mode_in),
    .src_data_in(src_data_in), .flags_in(flags_in), .done_out(done_out), .hit_wait_out(hit_wait_out),
    .known_out(known_out), .wb_out(wb_out), .flags_out(flags_out));

  // free-running core clock, 5 ns period
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  // condition per second opcode byte; f is {of, sf, zf, cf}
  function automatic logic cond(input logic [7:0] op, input logic [3:0] f);
    case (op)
      8'h42: cond = f[0];
      8'h43: cond = !f[0];
      8'h44: cond = f[1];
      8'h45: cond = !f[1];
      8'h46: cond = f[0] | f[1];
      8'h4C: cond = f[2] ^ f[3];
      8'h4E: cond = f[1] | (f[2] ^ f[3]);
      8'h4F: cond = !f[1] & (f[2] == f[3]);
      default: cond = 1'b0;
    endcase
  endfunction : cond

  // one instruction in, results judged one edge later; never drops valid, so calls chain back to back
  task automatic send(input logic [7:0] o0, input logic [7:0] op, input logic [3:0] f, input logic hit);
    logic kn, wr;
    logic [31:0] fw, src;
    fw = {16'hA5A5, 4'h0, f[3], 3'h0, f[2], f[1], 5'h0, f[0]};
    src = {op, f, 4'h3, 16'hC0DE} ^ fw;
    kn = (o0 == 8'h0F) && (op inside {8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4C, 8'h4E, 8'h4F});
    wr = kn && hit && cond(op, f);
    valid_in = 1'b1;
    insn_in = {o0, op, 2'b11, op[2:0] ^ f[2:0], 3'h5};
    cache_hit_in = hit;
    prot_mode_in = f[1];
    flags_in = fw;
    src_data_in = src;
    @(posedge clk_in);
    #1;
    check_word("known_out", {31'h0, kn}, {31'h0, known_out});
    check_word("done_out", {31'h0, kn & hit}, {31'h0, done_out});
    check_word("hit_wait_out", {31'h0, kn & !hit}, {31'h0, hit_wait_out});
    check_word("wr_en", {31'h0, wr}, {31'h0, wb_out.wr_en});
    if (wr) begin
      check_word("dst_idx", {29'h0, op[2:0] ^ f[2:0]}, {29'h0, wb_out.dst_idx});
      check_word("wb_data", src, wb_out.data);
    end
    check_word("flags_out", fw, flags_out);
  endtask : send

  // every decoded move against all sixteen flag mixes, hit, one per clock
  task automatic t_all_moves();
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 16; j++) begin
        send(8'h0F, moves[i], j[3:0], 1'b1);
      end
    end
  endtask : t_all_moves

  // a miss must not complete nor write, even with the condition true
  task automatic t_miss();
    for (int i = 0; i < 8; i++) begin
      send(8'h0F, moves[i], 4'hF - i[3:0], 1'b0);
    end
  endtask : t_miss

  // neighbouring opcodes and a wrong escape byte are not moves
  task automatic t_unknown();
    send(8'h0F, 8'h47, 4'h0, 1'b1);
    send(8'h0F, 8'h4D, 4'h0, 1'b1);
    send(8'h0E, 8'h44, 4'h2, 1'b1);
    send(8'h0F, 8'h44, 4'h2, 1'b1);
  endtask : t_unknown

  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // watchdog: the run needs under 300 cycles
  initial begin
    #(2000 * 5);
    fails++;
    final_report();
  end

  initial begin
    arst_n_in = 1'b0;
    valid_in = 1'b0;
    insn_in = '0;
    cache_hit_in = 1'b0;
    prot_mode_in = 1'b0;
    src_data_in = 32'h0000_0000;
    flags_in = 32'h0000_0000;
    repeat (20) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    @(posedge clk_in);
    #1;
    t_all_moves();
    t_miss();
    t_unknown();
    valid_in = 1'b0;
    @(posedge clk_in);
    #1;
    check_word("idle_done", 32'h0000_0000, {31'h0, done_out});
    final_report();
  end
endmodule : tb
`default_nettype wire
